/* File: wcd_crc_tree.sv */
// Constants shared by the write-check path, and the check-bit tree.
// Assumes an x8 lane set in chopped bursts and a combinational caller.
`timescale 1ns/100ps

//------------------------------------------------------------------
// Shared constants
//------------------------------------------------------------------
package wcd_pkg;
	// Tree inputs: 9 lanes of 4 beats, lane-major (bit 4*lane+beat)
	localparam int          TREE_IN_W = 36;
	localparam int          DVEC_W    = 72;
	localparam int          CRC_W     = 8;
	localparam int          BEAT_BITS = 16;
	// Tap masks over the tree inputs, one per check bit
	localparam logic [35:0] CRC_TAP [8] = '{
		36'hD179C0D11, 36'h639A51723, 36'h065C63257, 36'h1CB9C65AE,
		36'h39728DA5C, 36'h72E51A5A8, 36'hF4DA34B40, 36'hE8B468680};
	// Parity of the constant-one terms of each check bit
	localparam logic [7:0]  CRC_ONES  = 8'h71;
	// Beat positions within a link burst
	localparam logic [3:0]  BEAT_CRC        = 4'h8;
	localparam logic [3:0]  BEAT_LAST_CHECK = 4'h9;
	localparam logic [3:0]  BEAT_LAST_PLAIN = 4'h7;
	localparam logic [3:0]  BEAT_DATA_END   = 4'h8;
	localparam logic [3:0]  BEAT_CHOP_END   = 4'h4;
	// Alert low times, in command clocks
	localparam logic [5:0]  CHECK_PULSE_CYCLES  = 6'h08;
	localparam logic [5:0]  PARITY_PULSE_CYCLES = 6'h2E;
	// Values after reset
	localparam logic        STATUS_RST = 1'h0;
	localparam logic [5:0]  ALERT_RST  = 6'h00;

	typedef enum logic [1:0] {
		FN_NONE   = 2'b00,
		FN_MASK   = 2'b01,
		FN_INVERT = 2'b10,
		FN_TERM   = 2'b11
	} wcd_pin_fn_e;
endpackage : wcd_pkg

//------------------------------------------------------------------
// Check-bit tree
//------------------------------------------------------------------
module wcd_crc_tree
	import wcd_pkg::*;
(
	// Received lane bits and burst attributes
	input  wire logic [TREE_IN_W-1:0] rx_bits,
	input  wire logic                 col_a2,
	input  wire logic                 pin_lane_en,
	// Computed check bits
	output logic      [CRC_W-1:0]     crc
);
	logic [DVEC_W-1:0]    dvec;
	logic [TREE_IN_W-1:0] tree_in;

	// Place each received nibble at its numbered position, unused half at one
	for (genvar l = 0; l < 9; l++)
	begin : g_lane
		assign dvec[8*l +: 8] = col_a2 ? {rx_bits[4*l +: 4], 4'hF}
		                               : {4'hF, rx_bits[4*l +: 4]};
		if (l == 8)
		begin : g_pin
			// Pin lane counts only when mask or inversion owns it
			assign tree_in[32 +: 4] = !pin_lane_en ? 4'hF :
				(col_a2 ? dvec[68 +: 4] : dvec[64 +: 4]); // (R4)
		end
		else
		begin : g_dq
			// Upper nibble stands in for the lower one when a2 is high
			assign tree_in[4*l +: 4] = col_a2 ? dvec[8*l+4 +: 4]
			                                 : dvec[8*l +: 4]; // (R2) (R3)
		end
	end

	// One XOR tree per check bit, constant ones folded in
	for (genvar i = 0; i < CRC_W; i++)
	begin : g_bit
		assign crc[i] = ^(tree_in & CRC_TAP[i]) ^ CRC_ONES[i]; // (R1)
	end
endmodule : wcd_crc_tree

/* File: wcd_write_path.sv */
// Write data path: link capture, inversion, check compare, alert, status.
// Assumes a free command clock, a strobe clock that runs during bursts,
// and quasi-static mode bits changed only while the link is idle.
//
// Contract
// (R1) Eight check bits from fixed XOR trees
// (R2) Column bit two selects the tree
// (R3) Upper nibbles replace lower when bit set
// (R4) Pin lane used only if mask/invert
// (R5) Check errors share the alert line
// (R6) Check pulse short, parity pulse long
// (R7) Controller tells errors apart by status/width
// (R8) Controller tolerates merged alert low periods
// (R9) Mismatch sets sticky check-error status bit
// (R10) Status bit also sets error-log flag
// (R11) Both hold until mode write clears
// (R12) Controller retries writes on check alert
// (R13) Controller keeps write history for replay
// (R14) Pulse spans drive-low until release
// (R15) Inversion only in x8 and x16
// (R16) Inversion flag per byte per transfer
// (R17) Controller never enables mask with inversion
// (R18) No read inversion during multipurpose reads
// (R19) Termination strobe excludes mask and inversion
// (R20) Flag low inverts lane, high stores as-is
// (R21) x8 burst: eight bytes, each with flag
// (R22) x16: per-byte pins, one bit per transfer
// (R23) Compare at burst end, alert next cycle; here alert follows the command-side hand-over by one edge
// (R24) Fixed pulse length, restarted by new error
`timescale 1ns/100ps

module wcd_write_path
	import wcd_pkg::*;
(
	// Command clock domain
	input  wire logic                   clock,
	input  wire logic                   clk_en,
	input  wire logic                   arst_n,
	// Link strobe domain
	input  wire logic                   link_clk,
	// Mode configuration
	input  wire logic                   write_check_enable,
	input  wire logic                   write_mask_enable_bit,
	input  wire logic                   write_invert_enable_bit,
	input  wire logic                   read_invert_enable_bit,
	input  wire logic                   termination_strobe_enable_bit,
	input  wire logic                   x4_mode,
	input  wire logic                   x16_mode,
	input  wire logic                   mpr_read_active,
	// Mode register write of the status bit
	input  wire logic                   mode_register_write_cmd,
	input  wire logic                   mrw_status_value,
	// Command/address parity error event
	input  wire logic                   parity_error,
	// Link pins, sampled on link_clk
	input  wire logic                   link_frame,
	input  wire logic                   column_address_bit_two,
	input  wire logic                   burst_chop_four,
	input  wire logic [15:0]            link_dq,
	input  wire logic                   lower_byte_invert_flag,
	input  wire logic                   upper_byte_invert_flag,
	// Core write port
	output logic                        wr_valid,
	output logic      [8*BEAT_BITS-1:0] wr_data,
	output logic      [15:0]            wr_mask,
	output logic                        wr_chop,
	output logic                        wr_check_fail,
	// Status
	output logic                        check_error_status_bit,
	output logic                        error_log_check_flag,
	output logic      [1:0]             pin_function,
	output logic                        config_conflict,
	output logic                        read_invert_active,
	// Open-drain alert
	output logic                        alert_o,
	output logic                        alert_oe
);
	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------
	// Received byte as stored: flipped when inversion owns a low flag
	function automatic logic [7:0] lane_store(input logic [7:0] b, input logic flag_n,
		input logic inv_on);
		lane_store = (inv_on && !flag_n) ? ~b : b;
	endfunction : lane_store

	//------------------------------------------------------------------
	// Reset release, one copy per domain
	//------------------------------------------------------------------
	logic rst_s1_reg, rst_n_sync;
	logic lrst_s1_reg, lrst_n_sync;

	// Async assert, two-flop release
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_s1_reg <= 1'b0;
			rst_n_sync <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_n_sync <= rst_s1_reg;
		end
	end

	// Link side release; only completes once the strobe runs
	always_ff @(posedge link_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lrst_s1_reg <= 1'b0;
			lrst_n_sync <= 1'b0;
		end
		else
		begin
			lrst_s1_reg <= 1'b1;
			lrst_n_sync <= lrst_s1_reg;
		end
	end

	//------------------------------------------------------------------
	// Shared-pin function selection (command domain)
	//------------------------------------------------------------------
	logic        conflict_w, rd_inv_w;
	wcd_pin_fn_e fn_w;
	wcd_pin_fn_e fn_reg;
	logic        conflict_reg, rd_inv_reg, check_en_reg;

	// Illegal mixes leave the pin with no function rather than guess
	assign conflict_w = (write_mask_enable_bit && write_invert_enable_bit) ||
		(termination_strobe_enable_bit && (write_mask_enable_bit ||
		write_invert_enable_bit || read_invert_enable_bit || x16_mode)); // (R17) (R19)
	assign fn_w = (x4_mode || conflict_w)     ? FN_NONE :    // (R15)
		termination_strobe_enable_bit ? FN_TERM :
		write_invert_enable_bit       ? FN_INVERT :
		write_mask_enable_bit         ? FN_MASK : FN_NONE;
	assign rd_inv_w = read_invert_enable_bit && !x4_mode && !conflict_w &&
		!mpr_read_active; // (R18)

	// Registered configuration
	always_ff @(posedge clock or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			fn_reg       <= FN_NONE;
			conflict_reg <= 1'b0;
			rd_inv_reg   <= 1'b0;
			check_en_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			fn_reg       <= fn_w;
			conflict_reg <= conflict_w;
			rd_inv_reg   <= rd_inv_w;
			check_en_reg <= write_check_enable;
		end
	end

	//------------------------------------------------------------------
	// Configuration into the link domain
	//------------------------------------------------------------------
	// Levels only; they must settle while no burst is running
	logic [3:0] cfg_s1_reg, cfg_s2_reg;

	always_ff @(posedge link_clk or negedge lrst_n_sync)
	begin
		if (!lrst_n_sync)
		begin
			cfg_s1_reg <= 4'h0;
			cfg_s2_reg <= 4'h0;
		end
		else
		begin
			cfg_s1_reg <= {x16_mode, check_en_reg, fn_reg};
			cfg_s2_reg <= cfg_s1_reg;
		end
	end

	//------------------------------------------------------------------
	// Link capture (strobe domain)
	//------------------------------------------------------------------
	logic                   lk_x16, lk_chk, lk_inv, lk_msk, lk_pin_en;
	logic [3:0]             beat_reg, beat_next;
	logic                   a2_reg, a2_cur, bc4_reg;
	logic [127:0]           asm_reg, asm_next, hold_data_reg;
	logic [15:0]            msk_reg, msk_next, hold_mask_reg;
	logic [TREE_IN_W-1:0]   raw_reg, raw_next;
	logic [CRC_W-1:0]       crc_rx_reg, crc_calc;
	logic                   last_beat, hold_chop_reg, hold_fail_reg, done_tg_reg;
	logic [7:0]             lo_byte, hi_byte;
	logic                   lo_msk, hi_msk;

	assign lk_x16    = cfg_s2_reg[3];
	assign lk_chk    = cfg_s2_reg[2];
	assign lk_inv    = (cfg_s2_reg[1:0] == FN_INVERT);
	assign lk_msk    = (cfg_s2_reg[1:0] == FN_MASK);
	assign lk_pin_en = lk_inv || lk_msk;
	assign a2_cur    = (beat_reg == 4'h0) ? column_address_bit_two : a2_reg;
	// Check bursts carry two more beats; the last one closes the frame
	assign last_beat = link_frame &&
		(beat_reg == (lk_chk ? BEAT_LAST_CHECK : BEAT_LAST_PLAIN));
	assign beat_next = (!link_frame || last_beat) ? 4'h0 : beat_reg + 4'h1;

	// Per-byte flag decides inversion; each byte pin serves its own lane
	assign lo_byte = lane_store(link_dq[7:0], lower_byte_invert_flag, lk_inv); // (R20) (R21)
	assign hi_byte = lane_store(link_dq[15:8], upper_byte_invert_flag, lk_inv); // (R22)
	assign lo_msk  = lk_msk && !lower_byte_invert_flag;
	assign hi_msk  = !lk_x16 || (lk_msk && !upper_byte_invert_flag);

	// Next values of the assembly registers
	always_comb
	begin
		asm_next = asm_reg;
		msk_next = msk_reg;
		raw_next = raw_reg;
		if (link_frame && beat_reg < BEAT_DATA_END)
		begin
			asm_next[{beat_reg[2:0], 4'h0} +: 16] = {hi_byte, lo_byte}; // (R16)
			msk_next[{beat_reg[2:0], 1'b0} +: 2]  = {hi_msk, lo_msk};
		end
		// Tree sees wire values, before any inversion
		if (link_frame && beat_reg < BEAT_CHOP_END)
		begin
			for (int l = 0; l < 8; l++)
				raw_next[4*l + beat_reg[1:0]] = link_dq[l];
			raw_next[32 + beat_reg[1:0]] = lower_byte_invert_flag;
		end
	end

	wcd_crc_tree u_tree (
		.rx_bits     (raw_reg),
		.col_a2      (a2_reg),
		.pin_lane_en (lk_pin_en),
		.crc         (crc_calc)
	);

	// Beat counter and assembly
	always_ff @(posedge link_clk or negedge lrst_n_sync)
	begin
		if (!lrst_n_sync)
		begin
			beat_reg   <= 4'h0;
			a2_reg     <= 1'b0;
			bc4_reg    <= 1'b0;
			asm_reg    <= '0;
			msk_reg    <= '0;
			raw_reg    <= '0;
			crc_rx_reg <= '0;
		end
		else
		begin
			beat_reg <= beat_next;
			a2_reg   <= a2_cur;
			asm_reg  <= asm_next;
			msk_reg  <= msk_next;
			raw_reg  <= raw_next;
			if (link_frame && beat_reg == 4'h0)
				bc4_reg <= burst_chop_four;
			if (link_frame && beat_reg == BEAT_CRC)
				crc_rx_reg <= link_dq[7:0];
		end
	end

	// Burst end: compare and hand the burst over; hold stays for a burst
	always_ff @(posedge link_clk or negedge lrst_n_sync)
	begin
		if (!lrst_n_sync)
		begin
			hold_data_reg <= '0;
			hold_mask_reg <= '0;
			hold_chop_reg <= 1'b0;
			hold_fail_reg <= 1'b0;
			done_tg_reg   <= 1'b0;
		end
		else if (last_beat)
		begin
			hold_data_reg <= asm_next;
			hold_mask_reg <= msk_next;
			hold_chop_reg <= bc4_reg;
			hold_fail_reg <= lk_chk && bc4_reg && (crc_calc != crc_rx_reg); // (R23)
			done_tg_reg   <= ~done_tg_reg;
		end
	end

	//------------------------------------------------------------------
	// Burst hand-over into the command domain
	//------------------------------------------------------------------
	logic tg_s1_reg, tg_s2_reg, tg_s3_reg, burst_done;
	logic fail_event;

	assign burst_done = tg_s2_reg ^ tg_s3_reg;
	assign fail_event = wr_valid && wr_check_fail;

	// Toggle synchroniser; hold registers are stable when the edge shows
	always_ff @(posedge clock or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			tg_s1_reg <= 1'b0;
			tg_s2_reg <= 1'b0;
			tg_s3_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			tg_s1_reg <= done_tg_reg;
			tg_s2_reg <= tg_s1_reg;
			tg_s3_reg <= tg_s2_reg;
		end
	end

	// Core write port
	always_ff @(posedge clock or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			wr_valid      <= 1'b0;
			wr_data       <= '0;
			wr_mask       <= '0;
			wr_chop       <= 1'b0;
			wr_check_fail <= 1'b0;
		end
		else if (clk_en)
		begin
			wr_valid <= burst_done;
			if (burst_done)
			begin
				wr_data       <= hold_data_reg;
				wr_mask       <= hold_mask_reg;
				wr_chop       <= hold_chop_reg;
				wr_check_fail <= hold_fail_reg;
			end
		end
	end

	//------------------------------------------------------------------
	// Sticky status and alert pulse
	//------------------------------------------------------------------
	logic       status_next;
	logic [5:0] alert_cnt_reg, alert_cnt_next;

	// A mismatch in the clearing cycle still sets the bit
	assign status_next = fail_event ? 1'b1 :                    // (R9)
		(mode_register_write_cmd ? mrw_status_value : check_error_status_bit); // (R11)

	// Parity holds the line long; a check error restarts a short pulse
	assign alert_cnt_next =
		parity_error ? PARITY_PULSE_CYCLES :                    // (R6)
		(fail_event && alert_cnt_reg < CHECK_PULSE_CYCLES) ? CHECK_PULSE_CYCLES : // (R24)
		(alert_cnt_reg != ALERT_RST) ? alert_cnt_reg - 6'h01 : ALERT_RST;

	// Status copies and the shared open-drain driver
	always_ff @(posedge clock or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			check_error_status_bit <= STATUS_RST;
			error_log_check_flag   <= STATUS_RST;
			alert_cnt_reg          <= ALERT_RST;
			alert_oe               <= 1'b0;
			alert_o                <= 1'b0;
			pin_function           <= FN_NONE;
			config_conflict        <= 1'b0;
			read_invert_active     <= 1'b0;
		end
		else if (clk_en)
		begin
			check_error_status_bit <= status_next;
			error_log_check_flag   <= status_next;              // (R10)
			alert_cnt_reg          <= alert_cnt_next;
			alert_oe               <= (alert_cnt_next != ALERT_RST); // (R5) (R14)
			alert_o                <= 1'b0;                     // Drives low only
			pin_function           <= fn_reg;
			config_conflict        <= conflict_reg;
			read_invert_active     <= rd_inv_reg;
		end
	end
endmodule : wcd_write_path

/* File: wcd_write_path_sva.sv */
// Assertion checker for the write path, bound to its top module.
// Assumes one command clock domain and the raw asynchronous reset.
`timescale 1ns/100ps

module wcd_write_path_sva
	import wcd_pkg::*;
(
	// Clock, reset and run enable
	input  wire logic       clock,
	input  wire logic       arst_n,
	input  wire logic       clk_en,
	// Events and mode inputs
	input  wire logic       parity_error,
	input  wire logic       mode_register_write_cmd,
	input  wire logic       mrw_status_value,
	input  wire logic       mpr_read_active,
	input  wire logic       x4_mode,
	// Observed outputs
	input  wire logic       wr_valid,
	input  wire logic       wr_check_fail,
	input  wire logic       check_error_status_bit,
	input  wire logic       error_log_check_flag,
	input  wire logic [1:0] pin_function,
	input  wire logic       config_conflict,
	input  wire logic       read_invert_active,
	input  wire logic       alert_o,
	input  wire logic       alert_oe
);
	// Fail event as the alert logic takes it
	wire fail_ev = wr_valid && wr_check_fail && clk_en;
	wire quiet   = !parity_error && !fail_ev;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	// Cycles left of the long parity low time; 46 cycles exceed a repetition
	logic [5:0] par_left_reg;
	always_ff @(posedge clock or negedge arst_n)
		if (!arst_n)
			par_left_reg <= 6'h00;
		else if (parity_error && clk_en)
			par_left_reg <= PARITY_PULSE_CYCLES;
		else if (par_left_reg != 6'h00 && clk_en)
			par_left_reg <= par_left_reg - 6'h01;

	// A lone check error: event from idle, then eight quiet cycles
	sequence lone_fail_s;
		fail_ev && !parity_error && !alert_oe ##1 quiet[*8];
	endsequence

	fail_pulse_a: assert property (fail_ev |=> alert_oe[*8])
		else $error("check alert shorter than eight cycles");
	pulse_end_a: assert property (lone_fail_s |=> !alert_oe)
		else $error("check alert held past eight cycles");
	parity_hold_a: assert property (par_left_reg != 6'h00 |-> alert_oe)
		else $error("parity alert released too early");
	status_set_a: assert property (fail_ev |=> check_error_status_bit)
		else $error("status bit not set by check error");
	flag_copy_a: assert property (error_log_check_flag == check_error_status_bit)
		else $error("error log flag differs from status bit");
	status_hold_a: assert property (check_error_status_bit && !mode_register_write_cmd
		|=> check_error_status_bit)
		else $error("status bit dropped without a mode write");
	status_clear_a: assert property (mode_register_write_cmd && !mrw_status_value && clk_en
		&& !fail_ev |=> !check_error_status_bit)
		else $error("status bit not cleared by mode write");
	alert_cause_a: assert property ($rose(alert_oe) |-> $past(fail_ev) || $past(parity_error))
		else $error("alert driven without a cause");
	drive_low_a: assert property (alert_oe |-> !alert_o)
		else $error("alert driven high");
	conflict_none_a: assert property (config_conflict |-> pin_function == FN_NONE)
		else $error("pin function active in conflicting mode");
	x4_off_a: assert property (x4_mode[*3] |-> pin_function == FN_NONE && !read_invert_active)
		else $error("pin function active in x4 mode");
	mpr_off_a: assert property (mpr_read_active[*3] |-> !read_invert_active)
		else $error("read inversion during multipurpose read");
endmodule : wcd_write_path_sva

bind wcd_write_path wcd_write_path_sva u_sva (.clock, .arst_n, .clk_en, .parity_error,
	.mode_register_write_cmd, .mrw_status_value, .mpr_read_active, .x4_mode, .wr_valid,
	.wr_check_fail, .check_error_status_bit, .error_log_check_flag, .pin_function,
	.config_conflict, .read_invert_active, .alert_o, .alert_oe);

/* File: wcd_link_ctrl.sv */
// Controller-side link model: strobe clock and write bursts.
// Assumes the bench calls its tasks one at a time, never overlapping.
`timescale 1ns/100ps

module wcd_link_ctrl
(
	// Link pins towards the device
	output logic        link_clk,
	output logic        link_frame,
	output logic        column_address_bit_two,
	output logic        burst_chop_four,
	output logic [15:0] link_dq,
	output logic        lower_byte_invert_flag,
	output logic        upper_byte_invert_flag
);
	// Idle link; the strobe stands still until a task runs it
	initial
	begin
		link_clk               = 1'b0;
		link_frame             = 1'b0;
		column_address_bit_two = 1'b0;
		burst_chop_four        = 1'b0;
		link_dq                = 16'h5A3C;
		lower_byte_invert_flag = 1'b1;
		upper_byte_invert_flag = 1'b1;
	end

	// Strobe edges with no frame, 48 ns period
	task automatic idle(input int n);
		repeat (n)
		begin
			#24 link_clk = 1'b1;
			#24 link_clk = 1'b0;
		end
	endtask : idle

	// One burst; pins change only while the strobe is low
	task automatic burst(input logic a2, input logic [127:0] d, input logic [7:0] lp,
		input logic [7:0] up, input logic [7:0] crc);
		for (int k = 0; k < 10; k++)
		begin
			link_frame             = 1'b1;
			column_address_bit_two = a2;
			burst_chop_four        = 1'b1;
			link_dq = (k < 8) ? d[16*k +: 16] : {8'hFF, (k == 8) ? crc : 8'hFF};
			lower_byte_invert_flag = (k < 8) ? lp[k] : 1'b1;
			upper_byte_invert_flag = (k < 8) ? up[k] : 1'b1;
			#24 link_clk = 1'b1;
			#24 link_clk = 1'b0;
		end
		// Released lines show no stale value
		link_frame             = 1'b0;
		link_dq                = ~link_dq;
		lower_byte_invert_flag = ~lower_byte_invert_flag;
		upper_byte_invert_flag = ~upper_byte_invert_flag;
		idle(1);
	endtask : burst
endmodule : wcd_link_ctrl

/* File: wcd_write_path_tb.sv */
// Self-checking bench for the write path with a link controller model.
// Assumes a 20 MHz command clock; run enable and check enable stay high.
`timescale 1ns/100ps

module wcd_write_path_tb
	import wcd_pkg::*;
;
	logic         clock = 1'b0;
	logic         arst_n = 1'b0;
	logic         mask_en = 1'b0, inv_en = 1'b0, rd_inv = 1'b0, term_en = 1'b0;
	logic         x4 = 1'b0, x16 = 1'b1, multipurpose_register = 1'b0, mrw = 1'b0, parity = 1'b0, mrw_val = 1'b0;
	logic         lclk, frame, a2, chop, lpin, upin;
	logic [15:0]  dq;
	logic         wr_valid, wr_chop, wr_fail, status, flag, conflict, rd_act, al_o, al_oe;
	logic [127:0] wr_data;
	logic [15:0]  wr_mask;
	logic [1:0]   pin_fn;
	int           failures = 0;
	int           samples_checked = 0;
	// Shared alert line with the controller's pull-up
	wire          alert_line = al_oe ? al_o : 1'b1;

	always #25 clock = ~clock;

	wcd_link_ctrl link (.link_clk(lclk), .link_frame(frame), .column_address_bit_two(a2),
		.burst_chop_four(chop), .link_dq(dq), .lower_byte_invert_flag(lpin),
		.upper_byte_invert_flag(upin));

	wcd_write_path dut (.clock(clock), .clk_en(1'b1), .arst_n(arst_n), .link_clk(lclk),
		.write_check_enable(1'b1), .write_mask_enable_bit(mask_en),
		.write_invert_enable_bit(inv_en), .read_invert_enable_bit(rd_inv),
		.termination_strobe_enable_bit(term_en), .x4_mode(x4), .x16_mode(x16),
		.mpr_read_active(multipurpose_register), .mode_register_write_cmd(mrw), .mrw_status_value(mrw_val),
		.parity_error(parity), .link_frame(frame), .column_address_bit_two(a2),
		.burst_chop_four(chop), .link_dq(dq), .lower_byte_invert_flag(lpin),
		.upper_byte_invert_flag(upin), .wr_valid(wr_valid), .wr_data(wr_data),
		.wr_mask(wr_mask), .wr_chop(wr_chop), .wr_check_fail(wr_fail),
		.check_error_status_bit(status), .error_log_check_flag(flag), .pin_function(pin_fn),
		.config_conflict(conflict), .read_invert_active(rd_act), .alert_o(al_o),
		.alert_oe(al_oe));

	//----------------------------------------------------------
	// Helpers
	//----------------------------------------------------------
	task automatic check(input logic [127:0] seen, input logic [127:0] want, input string what);
		samples_checked++;
		if (seen !== want)
		begin
			failures++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask : check

	task automatic conclude;
		if (failures == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	// Next n command edges, then let their updates land
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step

	// Count low cycles of the alert line from the current cycle on, without waiting for a low one, bounded
	task automatic alert_len(input int want);
		int n;
		n = 0;
		while (alert_line === 1'b0 && n < 60)
		begin
			n++;
			step(1);
		end
		check(n, want, "alert low time");
	endtask : alert_len

	// Wait, bounded, for the core write port to hand a burst over
	task automatic await_write;
		for (int n = 0; n < 20 && wr_valid !== 1'b1; n++)
			step(1);
		check(wr_valid, 1'b1, "burst not delivered");
	endtask : await_write

	// Check bits over beats 0..3, lane-major tree inputs
	function automatic logic [7:0] exp_crc(input logic [127:0] d, input logic [7:0] lp,
		input logic pin_on);
		logic [35:0] t;
		for (int b = 0; b < 4; b++)
		begin
			for (int l = 0; l < 8; l++)
				t[4*l+b] = d[16*b+l];
			t[32+b] = pin_on ? lp[b] : 1'b1;
		end
		for (int i = 0; i < 8; i++)
			exp_crc[i] = ^(t & CRC_TAP[i]) ^ CRC_ONES[i];
	endfunction : exp_crc

	//----------------------------------------------------------
	// Scenarios
	//----------------------------------------------------------
	// Mode combinations against pin function, conflict and read inversion
	task automatic s_config;
		logic [9:0] tbl [7] = '{10'b1000000100, 10'b0101001001, 10'b1100000010,
			10'b0010001100, 10'b0011000010, 10'b0100100000, 10'b0001010000};
		foreach (tbl[i])
		begin
			{mask_en, inv_en, term_en, rd_inv, x4, multipurpose_register} = tbl[i][9:4];
			x16 = 1'b0;
			step(3);
			check({pin_fn, conflict, rd_act}, tbl[i][3:0], "mode decode");
		end
		{term_en, rd_inv, x4, multipurpose_register, x16} = 5'b00001;
	endtask : s_config

	// Chopped burst in a pin mode (0 none, 1 mask, 2 invert), optional bad check bits
	task automatic s_burst(input int fn, input logic a_two, input logic [7:0] flip);
		logic [127:0] d = 128'h3C96_E10F_7A25_C3B8_5D4E_A1F2_0B69_87D4;
		logic [7:0]   lp = 8'hA6;
		logic [7:0]   up = 8'h5C;
		logic [63:0]  want_d;
		logic [7:0]   want_m;
		mask_en = (fn == 1);
		inv_en  = (fn == 2);
		fork
			step(4);
			link.idle(4);
		join
		for (int k = 0; k < 4; k++)
		begin
			want_d[16*k +: 8]   = (fn == 2 && !lp[k]) ? ~d[16*k +: 8] : d[16*k +: 8];
			want_d[16*k+8 +: 8] = (fn == 2 && !up[k]) ? ~d[16*k+8 +: 8] : d[16*k+8 +: 8];
			want_m[2*k]         = (fn == 1 && !lp[k]);
			want_m[2*k+1]       = (fn == 1 && !up[k]);
		end
		link.burst(a_two, d, lp, up, exp_crc(d, lp, fn != 0) ^ flip);
		await_write();
		check(wr_data[63:0], want_d, "write data");
		check(wr_mask[7:0], want_m, "write mask");
		check(wr_chop, 1'b1, "chop flag");
		check(wr_fail, flip != 8'h00, "check result");
		if (flip != 8'h00)
		begin
			// Alert starts one edge after the failing hand-over
			step(1);
			alert_len(CHECK_PULSE_CYCLES);
			check({status, flag}, 2'b11, "sticky status");
			// Replay the kept write, this time with good check bits
			link.burst(a_two, d, lp, up, exp_crc(d, lp, fn != 0));
			await_write();
			check(wr_fail, 1'b0, "replayed write");
		end
	endtask : s_burst

	// Long parity pulse, status kept, then cleared by a mode write
	task automatic s_parity_clear;
		parity = 1'b1;
		step(1);
		parity = 1'b0;
		alert_len(PARITY_PULSE_CYCLES);
		check({status, flag}, 2'b11, "status kept");
		// A mode write of one keeps the bit, a write of zero clears it
		{mrw, mrw_val} = 2'b11;
		step(1);
		check({status, flag}, 2'b11, "status kept by write of one");
		mrw_val = 1'b0;
		step(1);
		mrw = 1'b0;
		step(1);
		check({status, flag}, 2'b00, "status cleared");
	endtask : s_parity_clear

	//----------------------------------------------------------
	// Main sequence and watchdog
	//----------------------------------------------------------
	initial
	begin
		fork
			step(3);
			link.idle(2);
		join
		arst_n = 1'b1;
		step(4);
		s_config();
		s_burst(2, 1'b0, 8'h00);
		s_burst(1, 1'b1, 8'h00);
		s_burst(0, 1'b1, 8'h80);
		s_burst(2, 1'b0, 8'h01);
		s_parity_clear();
		conclude();
	end

	// Watchdog far beyond the ten or so microseconds the run needs
	initial
	begin
		#100us;
		failures++;
		conclude();
	end
endmodule : wcd_write_path_tb
